// ### verilog/ppm_cfg.svh
// What this block does
// R1 - strap low permits software power saving
// R2 - strap high blocks power saving requests
// R3 - strap low at reset: watchdog stopped
// R4 - strap high at reset: watchdog autostarts
// R5 - reset pin low one machine cycle
// R6 - latch one gives weak pull-up input
// R7 - strobe port alternates need latch one
// R8 - capture inputs need latch; compare overrides
// R9 - input port feeds digital and analog
// R10 - compare channels zero-seven onto pins
// R11 - strobe port bit assignment fixed
// R12 - write strobe pulses, read strobe enables
// R13 - capture port bit assignment fixed
// R14 - programmer drives low address on port
// R15 - active-low reset request output
// R16 - strap and reset sampled synchronously
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH
`define PPM_MACHINE_CYCLE_NS   96
`define PPM_CLK_PERIOD_NS      8
`define PPM_RST_CYCLES         ((`PPM_MACHINE_CYCLE_NS + `PPM_CLK_PERIOD_NS - 1) / `PPM_CLK_PERIOD_NS)
`define PPM_BIT_RXD            0
`define PPM_BIT_TXD            1
`define PPM_BIT_WR             6
`define PPM_BIT_RD             7
`define PPM_BIT_SYSTEM_CLOCK_PIN         6
`define PPM_LATCH_RESET        8'hFF
`endif

// ### verilog/ppm_pkg.sv
package ppm_pkg;
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
        logic [7:0] pu;
    } ppm_pins_t;
    typedef enum logic [0:0] {
        PPM_RUN   = 1'b0,
        PPM_RESET = 1'b1
    } ppm_rst_state_t;
endpackage

// ### verilog/ppm_port_pin_function_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppm_cfg.svh"
module ppm_port_pin_function_mux #(
    parameter int RST_CYCLES = `PPM_RST_CYCLES
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // pins in
    input  wire logic             reset_pin_n,
    input  wire logic             powersave_permit_watchdog_strap,
    input  wire logic [7:0]       p1_in,
    input  wire logic [7:0]       p3_in,
    input  wire logic [7:0]       p4_in,
    input  wire logic [7:0]       p7_in,
    // core side
    input  wire logic [7:0]       p1_latch,
    input  wire logic [7:0]       p3_latch,
    input  wire logic [7:0]       p4_latch,
    input  wire logic [7:0]       compare_out,
    input  wire logic [4:0]       cc_compare_out,
    input  wire logic [4:0]       cc_compare_en,
    input  wire logic             compare_sel,
    input  wire logic             system_clock_en,
    input  wire logic             serial_tx_value,
    input  wire logic             serial_sync_rx_drive,
    input  wire logic             serial_sync_rx_value,
    input  wire logic             ext_wr_strobe,
    input  wire logic             ext_rd_strobe,
    input  wire logic             sw_powersave_req,
    input  wire logic             wdt_reset_req,
    input  wire logic             osc_wdt_reset_req,
    // pins out
    output ppm_pkg::ppm_pins_t    p1_pins,
    output ppm_pkg::ppm_pins_t    p3_pins,
    output ppm_pkg::ppm_pins_t    p4_pins,
    output logic                  reset_request_out_n,
    // core results
    output logic                  powersave_grant,
    output logic                  watchdog_autostart,
    output logic                  core_reset,
    output logic [7:0]            p7_digital,
    output logic [7:0]            analog_channel_sel_valid,
    output logic                  serial_rx_pin_zero,
    output logic                  ext_irq_gate_zero,
    output logic                  ext_irq_gate_one,
    output logic                  counter_zero_input,
    output logic                  counter_one_input,
    output logic [4:0]            capture_in,
    output logic                  ext_irq_two,
    output logic [3:0]            ext_irq_three_six,
    output logic                  timer_two_reload_trigger,
    output logic                  counter_two_input
);
    //////////////////////////////////////////////////////////////////////
    // synchronisers for reset pin and strap
    logic [1:0] rpin_sync;
    logic [1:0] strap_sync;
    logic [1:0] next_rpin_sync;
    logic [1:0] next_strap_sync;

    // R16 sync stage
    always_comb begin
        next_rpin_sync  = {rpin_sync[0], reset_pin_n};
        next_strap_sync = {strap_sync[0], powersave_permit_watchdog_strap};
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            // pin counts as low until seen high, so the strap is sampled first
            rpin_sync  <= 2'h0;
            strap_sync <= 2'h3;
        end else begin
            rpin_sync  <= next_rpin_sync;
            strap_sync <= next_strap_sync;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // reset filter and strap capture
    localparam int CW = $clog2(RST_CYCLES + 1);
    ppm_pkg::ppm_rst_state_t rst_state;
    ppm_pkg::ppm_rst_state_t next_rst_state;
    logic [CW-1:0]           low_cnt;
    logic [CW-1:0]           next_low_cnt;
    logic                    next_core_reset;
    logic                    next_autostart;
    logic                    next_ro_n;
    logic                    next_grant;

    always_comb begin
        next_low_cnt   = low_cnt;
        next_rst_state = rst_state;
        next_autostart = watchdog_autostart;
        // R5 low one machine cycle, RST_CYCLES clocks in a row
        if (rpin_sync[1]) begin
            next_low_cnt = '0;
        end else if (low_cnt != CW'(RST_CYCLES)) begin
            next_low_cnt = low_cnt + CW'(1);
        end
        unique case (rst_state)
            ppm_pkg::PPM_RUN: begin
                if (!rpin_sync[1] && low_cnt == CW'(RST_CYCLES - 1)) begin
                    next_rst_state = ppm_pkg::PPM_RESET;
                end
            end
            ppm_pkg::PPM_RESET: begin
                if (rpin_sync[1]) begin
                    next_rst_state = ppm_pkg::PPM_RUN;
                    // R3 R4 strap latched at release
                    next_autostart = strap_sync[1];
                end
            end
        endcase
        next_core_reset = (next_rst_state == ppm_pkg::PPM_RESET) || wdt_reset_req
                          || osc_wdt_reset_req;
        // R15 active-low request
        next_ro_n = !next_core_reset;
        // R1 R2 strap gates power saving
        next_grant = sw_powersave_req && !strap_sync[1] && !core_reset;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rst_state           <= ppm_pkg::PPM_RESET;
            low_cnt             <= '0;
            watchdog_autostart  <= 1'b0;
            core_reset          <= 1'b1;
            reset_request_out_n <= 1'b0;
            powersave_grant     <= 1'b0;
        end else begin
            rst_state           <= next_rst_state;
            low_cnt             <= next_low_cnt;
            watchdog_autostart  <= next_autostart;
            core_reset          <= next_core_reset;
            reset_request_out_n <= next_ro_n;
            powersave_grant     <= next_grant;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // pin function mux
    ppm_pkg::ppm_pins_t next_p1;
    ppm_pkg::ppm_pins_t next_p3;
    ppm_pkg::ppm_pins_t next_p4;
    logic [7:0]         next_p7;
    logic [7:0]         p1_en;
    logic [7:0]         p3_en;
    logic [16:0]        next_alt;
    logic [16:0]        alt;

    // quasi-bidirectional pin: strong low for zero, weak pull-up for one
    function automatic ppm_pkg::ppm_pins_t quasi(input logic [7:0] val);
        ppm_pkg::ppm_pins_t r;
        r.o  = 8'h00;
        r.oe = ~val;
        r.pu = val;
        return r;
    endfunction

    always_comb begin
        // R6 weak pull-up
        next_p4 = quasi(p4_latch);
        // R10 compare channel order
        if (compare_sel) begin
            next_p4.o  = compare_out;
            next_p4.oe = 8'hFF;
            next_p4.pu = 8'h00;
        end
        next_p3 = quasi(p3_latch);
        // R11 R12 strobe port map
        if (p3_latch[`PPM_BIT_TXD] && !serial_tx_value) begin
            next_p3.oe[`PPM_BIT_TXD] = 1'b1;
        end
        if (p3_latch[`PPM_BIT_RXD] && serial_sync_rx_drive && !serial_sync_rx_value) begin
            next_p3.oe[`PPM_BIT_RXD] = 1'b1;
        end
        if (p3_latch[`PPM_BIT_WR] && ext_wr_strobe) begin
            next_p3.oe[`PPM_BIT_WR] = 1'b1;
        end
        if (p3_latch[`PPM_BIT_RD] && ext_rd_strobe) begin
            next_p3.oe[`PPM_BIT_RD] = 1'b1;
        end
        next_p1 = quasi(p1_latch);
        // R8 compare overrides latch
        for (int i = 0; i < 5; i++) begin
            if (cc_compare_en[i]) begin
                next_p1.o[i]  = cc_compare_out[i];
                next_p1.oe[i] = 1'b1;
                next_p1.pu[i] = 1'b0;
            end
        end
        // R13 clock output pin carries rpin_sync[1], the synchronised reset pin level
        if (p1_latch[`PPM_BIT_SYSTEM_CLOCK_PIN] && system_clock_en) begin
            next_p1.o[`PPM_BIT_SYSTEM_CLOCK_PIN]  = rpin_sync[1];
            next_p1.oe[`PPM_BIT_SYSTEM_CLOCK_PIN] = 1'b1;
        end
        // R7 R8 alternate inputs gated by latch
        p3_en = p3_in & p3_latch;
        p1_en = p1_in & p1_latch;
        // R14 programmer address appears on p1_in unchanged
        next_alt = {p3_en[0], ~p3_en[2] & p3_latch[2], ~p3_en[3] & p3_latch[3],
                    p3_en[4], p3_en[5], p1_en[4:0], ~p1_en[4] & p1_latch[4],
                    ~p1_en[3:0] & p1_latch[3:0], p1_en[5], p1_en[7]};
        // R9 digital and analog
        next_p7 = p7_in;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            p1_pins    <= '{o: 8'h00, oe: 8'h00, pu: `PPM_LATCH_RESET};
            p3_pins    <= '{o: 8'h00, oe: 8'h00, pu: `PPM_LATCH_RESET};
            p4_pins    <= '{o: 8'h00, oe: 8'h00, pu: `PPM_LATCH_RESET};
            p7_digital <= 8'h00;
            alt        <= '0;
        end else begin
            p1_pins    <= next_p1;
            p3_pins    <= next_p3;
            p4_pins    <= next_p4;
            p7_digital <= next_p7;
            alt        <= next_alt;
        end
    end

    assign analog_channel_sel_valid = p7_digital;
    assign serial_rx_pin_zero       = alt[16];
    assign ext_irq_gate_zero        = alt[15];
    assign ext_irq_gate_one         = alt[14];
    assign counter_zero_input       = alt[13];
    assign counter_one_input        = alt[12];
    assign capture_in               = alt[11:7];
    assign ext_irq_two              = alt[6];
    assign ext_irq_three_six        = alt[5:2];
    assign timer_two_reload_trigger = alt[1];
    assign counter_two_input        = alt[0];

    //////////////////////////////////////////////////////////////////////
    // checks
    // R2 blocked while strap high
    property p_block;
        @(posedge clk_sys) disable iff (sys_rst) strap_sync[1] |=> !powersave_grant;
    endproperty
    a_block: assert property (p_block) else $error("power save granted with strap high"); // R2
    property p_permit;
        @(posedge clk_sys) disable iff (sys_rst)
            (sw_powersave_req && !strap_sync[1] && !core_reset) |=> powersave_grant;
    endproperty
    a_permit: assert property (p_permit) else $error("power save not granted"); // R1
    property p_ro;
        @(posedge clk_sys) disable iff (sys_rst)
            (wdt_reset_req || osc_wdt_reset_req) |=> !reset_request_out_n && core_reset;
    endproperty
    a_ro: assert property (p_ro) else $error("reset out mismatch"); // R15
    property p_wdt;
        @(posedge clk_sys) disable iff (sys_rst)
            (rst_state == ppm_pkg::PPM_RESET && rpin_sync[1])
            |=> watchdog_autostart == $past(strap_sync[1]);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog default wrong"); // R3 R4
    property p_rst;
        @(posedge clk_sys) disable iff (sys_rst)
            (!rpin_sync[1])[*8] ##1 !rpin_sync[1] ##1 !rpin_sync[1] ##1 !rpin_sync[1]
            ##1 !rpin_sync[1] |=> core_reset;
    endproperty
    a_rst: assert property (p_rst) else $error("reset not taken"); // R5
    property p_cmp;
        @(posedge clk_sys) disable iff (sys_rst) compare_sel |=> p4_pins.o == $past(compare_out);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare order wrong"); // R10
    property p_cc;
        @(posedge clk_sys) disable iff (sys_rst) cc_compare_en[0] |=> p1_pins.oe[0];
    endproperty
    a_cc: assert property (p_cc) else $error("compare not driven"); // R8
    property p_gate;
        @(posedge clk_sys) disable iff (sys_rst) !p3_latch[4] |=> !counter_zero_input;
    endproperty
    a_gate: assert property (p_gate) else $error("alternate input without latch"); // R7
    property p_pu;
        @(posedge clk_sys) disable iff (sys_rst)
            (!compare_sel && p4_latch[0]) |=> p4_pins.pu[0] && !p4_pins.oe[0];
    endproperty
    a_pu: assert property (p_pu) else $error("pull-up missing"); // R6
    property p_wr;
        @(posedge clk_sys) disable iff (sys_rst) ext_wr_strobe |=> p3_pins.oe[6] && !p3_pins.o[6];
    endproperty
    a_wr: assert property (p_wr) else $error("write strobe not driven"); // R12
    property p_rd;
        @(posedge clk_sys) disable iff (sys_rst) ext_rd_strobe |=> p3_pins.oe[7] && !p3_pins.o[7];
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe not driven"); // R12
    property p_clk;
        @(posedge clk_sys) disable iff (sys_rst) (p1_latch[6] && system_clock_en) |=> p1_pins.oe[6];
    endproperty
    a_clk: assert property (p_clk) else $error("clock output not driven"); // R13
    property p_p7;
        @(posedge clk_sys) disable iff (sys_rst) 1'b1 |=> p7_digital == $past(p7_in);
    endproperty
    a_p7: assert property (p_p7) else $error("input port level lost"); // R9
    property p_irq;
        @(posedge clk_sys) disable iff (sys_rst) (p1_latch[4] && !p1_in[4]) |=> ext_irq_two;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt two missed"); // R13
endmodule
`default_nettype wire

// ### dv/ppm_board.sv
`timescale 1ns/1ps
`default_nettype none
module ppm_board (
    // clock
    input  wire logic               clk_sys,
    // device side of the port
    input  wire ppm_pkg::ppm_pins_t pins,
    // external circuit
    input  wire logic [7:0]         ext_en,
    input  wire logic [7:0]         ext_val,
    // resolved pin levels
    output logic [7:0]              level
);
    logic [7:0] flt;
    // an undriven line wanders so a stale level never passes
    always_ff @(posedge clk_sys) begin
        flt <= ~level;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level[i] = pins.oe[i] ? pins.o[i] : ext_en[i] ? ext_val[i] : pins.pu[i] ? 1'b1 : flt[i];
        end
    end
endmodule
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int RST_CYCLES = 2;
    logic clk_sys, sys_rst, reset_pin_n, powersave_permit_watchdog_strap;
    logic [7:0] p1_in, p3_in, p4_in, p7_in, p1_latch, p3_latch, p4_latch, compare_out;
    logic [4:0] cc_compare_out, cc_compare_en, capture_in;
    logic compare_sel, system_clock_en, serial_tx_value, serial_sync_rx_drive;
    logic serial_sync_rx_value, ext_wr_strobe, ext_rd_strobe, sw_powersave_req;
    logic wdt_reset_req, osc_wdt_reset_req, reset_request_out_n, powersave_grant;
    logic watchdog_autostart, core_reset, serial_rx_pin_zero, ext_irq_gate_zero;
    logic ext_irq_gate_one, counter_zero_input, counter_one_input, ext_irq_two;
    logic timer_two_reload_trigger, counter_two_input;
    logic [7:0] p7_digital, analog_channel_sel_valid, e1, e3, e4, x1, x3, l1, l3;
    logic [3:0] ext_irq_three_six;
    logic [4:0] ex5;
    ppm_pkg::ppm_pins_t p1_pins, p3_pins, p4_pins;
    int err_total, comparisons, n;
    ppm_port_pin_function_mux #(.RST_CYCLES(RST_CYCLES)) dut (.*);
    ppm_board b1 (.clk_sys, .pins(p1_pins), .ext_en(x1), .ext_val(e1), .level(p1_in));
    ppm_board b3 (.clk_sys, .pins(p3_pins), .ext_en(x3), .ext_val(e3), .level(p3_in));
    ppm_board b4 (.clk_sys, .pins(p4_pins), .ext_en(8'hff), .ext_val(e4), .level(p4_in));
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wait_free;
        n = 0;
        while ((core_reset !== 1'b0 || reset_request_out_n !== 1'b1) && n < 12) begin
            cyc(1);
            n++;
        end
        chk(n < 12, "reset never ends");
        if (n >= 12) give_verdict();
    endtask
    task automatic pin_reset(input logic s);
        powersave_permit_watchdog_strap = s;
        reset_pin_n = 0;
        cyc(RST_CYCLES + 4);
        chk(core_reset === 1'b1, "core not reset");
        chk(reset_request_out_n === 1'b0, "reset out idle");
        reset_pin_n = 1;
        wait_free();
        chk(watchdog_autostart === s, "autostart wrong");
        powersave_permit_watchdog_strap = ~s;
        cyc(5);
        chk(watchdog_autostart === s, "autostart moved");
        $display("reset test strap %0d done", s);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {sys_rst, reset_pin_n, p1_latch, p3_latch, p4_latch} = {2'b11, 24'hff_ffff};
        {powersave_permit_watchdog_strap, p7_in, compare_out, cc_compare_out} = '0;
        {cc_compare_en, compare_sel, system_clock_en, serial_tx_value} = '0;
        {serial_sync_rx_drive, serial_sync_rx_value, ext_wr_strobe, ext_rd_strobe} = '0;
        {sw_powersave_req, wdt_reset_req, osc_wdt_reset_req, e1, e3, e4, x1, x3} = '0;
        err_total = 0;
        comparisons = 0;
        void'($urandom(49305));
        repeat (16) @(negedge clk_sys);
        sys_rst = 0;
        wait_free();
        reset_pin_n = 0;
        cyc(RST_CYCLES - 1);
        reset_pin_n = 1;
        cyc(6);
        chk(core_reset === 1'b0 && reset_request_out_n === 1'b1, "short pulse reset");
        $display("reset filter test done");
        pin_reset(1'b0);
        pin_reset(1'b1);
        for (int k = 0; k < 2; k++) begin
            {osc_wdt_reset_req, wdt_reset_req} = 2'(k + 1);
            cyc(4);
            chk(reset_request_out_n === 1'b0, "watchdog reset lost");
            chk(core_reset === 1'b1, "core kept running");
            {osc_wdt_reset_req, wdt_reset_req} = 2'h0;
            wait_free();
        end
        $display("watchdog reset test done");
        for (int s = 0; s < 2; s++) begin
            powersave_permit_watchdog_strap = s[0];
            sw_powersave_req = 1;
            cyc(5);
            chk(powersave_grant === ~s[0], "grant wrong");
            sw_powersave_req = 0;
            cyc(3);
            chk(powersave_grant === 1'b0, "grant stuck");
        end
        $display("powersave test done");
        for (int k = 0; k < 60; k++) begin
            {p1_latch, p3_latch, p4_latch, compare_out} = $urandom;
            {p7_in, e1, e3, e4} = $urandom;
            {x1, x3, cc_compare_out, cc_compare_en} = 26'($urandom);
            {compare_sel, system_clock_en, serial_tx_value, ext_wr_strobe, ext_rd_strobe,
             serial_sync_rx_drive, serial_sync_rx_value} = 7'($urandom);
            // pin levels from the rules: driven low, else outside driver, else pull-up
            l1 = p1_latch & (e1 | ~x1);
            l1[4:0] = (cc_compare_en & cc_compare_out) | (~cc_compare_en & l1[4:0]);
            l3 = p3_latch & (e3 | ~x3);
            if (serial_sync_rx_drive && !serial_sync_rx_value) l3[0] = 1'b0;
            cyc(3);
            chk(p7_digital === p7_in && analog_channel_sel_valid === p7_in, "p7");
            if (compare_sel) chk(p4_pins.o === compare_out, "compare port");
            else chk(p4_pins.pu === p4_latch, "p4 pull-up");
            for (int i = 0; i < 5; i++) begin
                if (cc_compare_en[i]) chk(p1_pins.o[i] === cc_compare_out[i], "cc out");
            end
            chk(capture_in === (p1_latch[4:0] & l1[4:0]), "capture in");
            ex5 = p1_latch[4:0] & ~l1[4:0];
            chk({ext_irq_two, ext_irq_three_six} === ex5, "p1 irqs");
            chk(timer_two_reload_trigger === l1[5], "reload");
            chk(counter_two_input === l1[7], "counter two");
            ex5 = {l3[5:4], p3_latch[3:2] & ~l3[3:2], l3[0]};
            chk({counter_one_input, counter_zero_input, ext_irq_gate_one, ext_irq_gate_zero,
                 serial_rx_pin_zero} === ex5, "p3 inputs");
            if (ext_wr_strobe) chk({p3_pins.oe[6], p3_pins.o[6]} === 2'b10, "wr");
            if (ext_rd_strobe) chk({p3_pins.oe[7], p3_pins.o[7]} === 2'b10, "rd");
            chk(p3_pins.oe[1] === (!p3_latch[1] || !serial_tx_value), "tx");
            chk(p1_pins.oe[6] === (!p1_latch[6] || system_clock_en), "clock out");
            chk(p3_pins.pu[5:2] === p3_latch[5:2], "p3 pull-up");
            chk({p1_pins.pu[7], p1_pins.pu[5]} === {p1_latch[7], p1_latch[5]}, "p1 pu");
        end
        $display("pin mux test done");
        give_verdict();
    end
endmodule
`default_nettype wire
